//--- src/jtp_cfg.svh
`ifndef JTP_CFG_SVH
`define JTP_CFG_SVH
`define JTP_IR_W 4
`define JTP_IR_CAPT 4'h1
`define JTP_OP_EXTEST 4'h0
`define JTP_OP_SAMPLE 4'h1
`define JTP_OP_IDCODE 4'h2
`define JTP_OP_HIGHZ 4'h3
`define JTP_OP_BYPASS 4'hF
`define JTP_ID_W 32
`define JTP_RESET_ONES 3'h5
`define JTP_ONES_W 3
`endif

//--- src/jtp_pkg.sv
package jtp_pkg;
   typedef enum logic [3:0] {
      TLR, RTI, SELDR, CAPDR, SHDR, EX1DR, PAUDR, EX2DR, UPDDR,
      SELIR, CAPIR, SHIR, EX1IR, PAUIR, EX2IR, UPDIR
   } jtp_state_t;
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trstN;
   } jtp_pins_t;
   typedef struct packed {
      logic tdo;
      logic tdoOe;
   } jtp_out_t;
endpackage

//--- src/jtp_tap.sv
`include "jtp_cfg.svh"
// What this block does
// - Five TMS-high clocks always reach reset.
// - Memory waits until the TAP was reset.
// - State moves on rising TCK by TMS.
// - Test-logic-reset disables all test logic.
// - Idle keeps test logic inactive here.
// - Select states branch to path or onward.
// - Capture-IR loads pattern ending in 01.
// - Shift-IR shifts instruction from TDI to TDO.
// - Exit1-IR branches; Pause-IR holds contents.
// - Exit2-IR goes to shift or update.
// - Update-IR latches instruction on falling TCK.
// - Capture-DR loads the selected register.
// - Data path mirrors the instruction path.
// - Instruction register is four bits, LSB first.
// - Bypass, boundary and ID registers in parallel.
// - Bypass is one stage, captures zero.
// - Bypass leaves normal function untouched.
// - Boundary cells load and read pins serially.
// - Test reset pin optional; TMS suffices.
// - Decode extest, sample, idcode, highz, bypass.
// - ID register is 32 bits, bit zero one.
// - High-impedance disables outputs, selects bypass.
module jtp_tap import jtp_pkg::*; #(
   parameter int BSR_W = 8,
   parameter logic [3:0] VERSION = 4'h0,
   parameter logic [15:0] PART_NUM = 16'h1234,  // Arbitrary value.
   parameter logic [10:0] MFR_ID = 11'h055      // Arbitrary value.
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire jtp_pins_t pins,
   input wire logic [BSR_W-1:0] pinIn,
   input wire logic [BSR_W-1:0] coreOut,
   output jtp_out_t tdoOut,
   output logic [BSR_W-1:0] pinOut,
   output logic pinOutOe,
   output logic memEnable
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Every pin passes two flops, so a TCK edge is seen about three clocks late.
   // The tester must therefore hold TCK high and low for at least four clocks.
   logic [3:0] syncA_reg, syncB_reg;
   logic tckPrev_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         syncA_reg <= 4'h0;
         syncB_reg <= 4'h0;
         tckPrev_reg <= 1'b0;
      end else begin
         syncA_reg <= pins;
         syncB_reg <= syncA_reg;
         tckPrev_reg <= syncB_reg[3];
      end
   end
   wire tckS = syncB_reg[3];
   wire tmsS = syncB_reg[2];
   wire tdiS = syncB_reg[1];
   wire trstS = ~syncB_reg[0];
   wire tckRise = tckS & ~tckPrev_reg;
   wire tckFall = ~tckS & tckPrev_reg;

   // ----------------------------------------
   // TAP state machine
   // ----------------------------------------
   // The state has no power-up reset of its own beyond the system reset;
   // the tester still resets it by TRST or TMS.
   jtp_state_t state_reg, state_next;
   always_comb begin
      case (state_reg)
         TLR: state_next = tmsS ? TLR : RTI;
         RTI: state_next = tmsS ? SELDR : RTI;
         SELDR: state_next = tmsS ? SELIR : CAPDR;
         CAPDR: state_next = tmsS ? EX1DR : SHDR;
         SHDR: state_next = tmsS ? EX1DR : SHDR;
         EX1DR: state_next = tmsS ? UPDDR : PAUDR;
         PAUDR: state_next = tmsS ? EX2DR : PAUDR;
         EX2DR: state_next = tmsS ? UPDDR : SHDR;
         UPDDR: state_next = tmsS ? SELDR : RTI;
         SELIR: state_next = tmsS ? TLR : CAPIR;
         CAPIR: state_next = tmsS ? EX1IR : SHIR;
         SHIR: state_next = tmsS ? EX1IR : SHIR;
         EX1IR: state_next = tmsS ? UPDIR : PAUIR;
         PAUIR: state_next = tmsS ? EX2IR : PAUIR;
         EX2IR: state_next = tmsS ? UPDIR : SHIR;
         UPDIR: state_next = tmsS ? SELDR : RTI;
         default: state_next = TLR;
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [`JTP_IR_W-1:0] irShift_reg, ir_reg;
   logic bypass_reg;
   logic [`JTP_ID_W-1:0] idShift_reg;
   logic [BSR_W-1:0] bsrShift_reg, bsrUpd_reg;
   logic tdo_reg, tdoOe_reg, memEn_reg, pinOe_reg;
   logic [BSR_W-1:0] pinOut_reg;
   logic [`JTP_ONES_W-1:0] ones_reg;
   wire [`JTP_ID_W-1:0] idValue = {VERSION, PART_NUM, MFR_ID, 1'b1};

   wire selBsr = (ir_reg == `JTP_OP_EXTEST) | (ir_reg == `JTP_OP_SAMPLE);
   wire selId = (ir_reg == `JTP_OP_IDCODE);
   wire extest = (ir_reg == `JTP_OP_EXTEST);
   wire highz = (ir_reg == `JTP_OP_HIGHZ);
   wire shifting = (state_reg == SHIR) | (state_reg == SHDR);
   wire drBit = selBsr ? bsrShift_reg[0] : (selId ? idShift_reg[0] : bypass_reg);
   wire tdoBit = (state_reg == SHIR) ? irShift_reg[0] : drBit;
   // Reset is held only while TRST is low; the five-ones count sends the state to reset separately, on the fifth TCK rise.
   wire tapReset = trstS;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= TLR;
         ones_reg <= '0;
      end else if (tapReset) begin
         state_reg <= TLR;
         ones_reg <= '0;
      end else if (tckRise) begin
         state_reg <= (ones_reg == `JTP_RESET_ONES - 3'h1 && tmsS) ? TLR : state_next;
         ones_reg <= tmsS ? ((ones_reg == `JTP_RESET_ONES) ? ones_reg : ones_reg + 3'h1) : '0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irShift_reg <= '0;
         bypass_reg <= 1'b0;
         idShift_reg <= '0;
         bsrShift_reg <= '0;
      end else if (tckRise) begin
         case (state_reg)
            CAPIR: irShift_reg <= `JTP_IR_CAPT;
            SHIR: irShift_reg <= {tdiS, irShift_reg[`JTP_IR_W-1:1]};
            CAPDR: begin
               bypass_reg <= 1'b0;
               if (selId) idShift_reg <= idValue;
               if (selBsr) bsrShift_reg <= pinIn;
            end
            SHDR: begin
               if (selBsr) bsrShift_reg <= {tdiS, bsrShift_reg[BSR_W-1:1]};
               else if (selId) idShift_reg <= {tdiS, idShift_reg[`JTP_ID_W-1:1]};
               else bypass_reg <= tdiS;
            end
            default: ;  // Pause and exit states hold.
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ir_reg <= `JTP_OP_BYPASS;
         bsrUpd_reg <= '0;
         tdo_reg <= 1'b0;
         tdoOe_reg <= 1'b0;
         memEn_reg <= 1'b0;
      end else begin
         if (state_reg == TLR) begin
            ir_reg <= `JTP_OP_BYPASS;
            memEn_reg <= 1'b1;
         end else if (tckFall && state_reg == UPDIR) begin
            ir_reg <= irShift_reg;
         end
         if (tckFall && state_reg == UPDDR && selBsr) bsrUpd_reg <= bsrShift_reg;
         if (tckFall) begin
            tdo_reg <= tdoBit;
            tdoOe_reg <= shifting;
         end
      end
   end

   // ----------------------------------------
   // Pin control
   // ----------------------------------------
   // Outside extest and high-impedance the core drives pins; bypass and
   // idcode never touch function.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pinOut_reg <= '0;
         pinOe_reg <= 1'b0;
      end else begin
         pinOut_reg <= extest ? bsrUpd_reg : coreOut;
         pinOe_reg <= ~highz;
      end
   end

   assign tdoOut = '{tdo: tdo_reg, tdoOe: tdoOe_reg};
   assign pinOut = pinOut_reg;
   assign pinOutOe = pinOe_reg;
   assign memEnable = memEn_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_trst_forces_reset: assert property (@(posedge clk) disable iff (!arst_n)
      trstS |=> state_reg == TLR) else $error("TRST did not reset TAP");
   a_capir_pattern: assert property (@(posedge clk) disable iff (!arst_n)
      (tckRise && state_reg == CAPIR && !trstS) |=> irShift_reg[1:0] == 2'h1)
      else $error("capture-IR pattern wrong");
   a_bypass_capture: assert property (@(posedge clk) disable iff (!arst_n)
      (tckRise && state_reg == CAPDR && !trstS) |=> !bypass_reg)
      else $error("bypass did not capture zero");
   a_tdo_enable_only: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(tdoOe_reg) |-> $past(tckFall) && $past(shifting))
      else $error("TDO enabled outside shift");
   a_state_on_rise: assert property (@(posedge clk) disable iff (!arst_n)
      (!tckRise && !trstS) |=> $stable(state_reg)) else $error("state moved off edge");
   a_ir_on_fall: assert property (@(posedge clk) disable iff (!arst_n)
      (!$past(tckFall) && state_reg != TLR && $past(state_reg) != TLR) |-> $stable(ir_reg))
      else $error("instruction changed off falling edge");
   a_tlr_bypass: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == TLR |=> ir_reg == `JTP_OP_BYPASS) else $error("reset did not clear IR");
   a_highz_outputs: assert property (@(posedge clk) disable iff (!arst_n)
      highz |=> !pinOutOe) else $error("outputs driven in high-Z");
   a_sel_exit_tlr: assert property (@(posedge clk) disable iff (!arst_n)
      (tckRise && !trstS && state_reg == SELIR && tmsS) |=> state_reg == TLR)
      else $error("select-IR did not return to reset");

   // ----------------------------------------
   // Sequencing checks
   // ----------------------------------------
   // These follow each register from its edge to the next clock, so a slip is caught at once.
   a_five_ones: assert property (@(posedge clk) disable iff (!arst_n)
      (tckRise && !trstS && tmsS && ones_reg == `JTP_RESET_ONES - 3'h1) |=> state_reg == TLR)
      else $error("five TMS ones did not reset TAP");

   a_tlr_mem: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == TLR |=> memEnable) else $error("memory not enabled after reset");

   a_mem_sticky: assert property (@(posedge clk) disable iff (!arst_n)
      memEnable |=> memEnable) else $error("memory enable dropped");

   a_seldr_branch: assert property (@(posedge clk) disable iff (!arst_n)
      (tckRise && !trstS && state_reg == SELDR && ones_reg != `JTP_RESET_ONES - 3'h1)
      |=> state_reg == ($past(tmsS) ? SELIR : CAPDR)) else $error("select-DR branch wrong");

   a_rti_idle: assert property (@(posedge clk) disable iff (!arst_n)
      (tckRise && !trstS && state_reg == RTI && !tmsS)
      |=> $stable(irShift_reg) && $stable(bypass_reg) && $stable(ir_reg))
      else $error("test logic active in idle");

   a_shir_shift: assert property (@(posedge clk) disable iff (!arst_n)
      (tckRise && !trstS && state_reg == SHIR)
      |=> irShift_reg == {$past(tdiS), $past(irShift_reg[`JTP_IR_W-1:1])})
      else $error("instruction shift wrong");

   a_pause_hold: assert property (@(posedge clk) disable iff (!arst_n)
      (tckRise && !trstS && (state_reg == PAUIR || state_reg == EX1IR))
      |=> $stable(irShift_reg)) else $error("instruction shifted in pause");

   a_exit2_branch: assert property (@(posedge clk) disable iff (!arst_n)
      (tckRise && !trstS && state_reg == EX2IR)
      |=> state_reg == ($past(tmsS) ? UPDIR : SHIR)) else $error("exit2 branch wrong");

   a_update_ir: assert property (@(posedge clk) disable iff (!arst_n)
      (tckFall && state_reg == UPDIR) |=> ir_reg == $past(irShift_reg))
      else $error("instruction not latched");

   a_capdr_id: assert property (@(posedge clk) disable iff (!arst_n)
      (tckRise && !trstS && state_reg == CAPDR && selId) |=> idShift_reg == idValue)
      else $error("identification not captured");

   a_capdr_bsr: assert property (@(posedge clk) disable iff (!arst_n)
      (tckRise && !trstS && state_reg == CAPDR && selBsr) |=> bsrShift_reg == $past(pinIn))
      else $error("pins not captured");

   a_shdr_bypass: assert property (@(posedge clk) disable iff (!arst_n)
      (tckRise && !trstS && state_reg == SHDR && !selBsr && !selId)
      |=> bypass_reg == $past(tdiS)) else $error("bypass shift wrong");

   a_pause_dr_hold: assert property (@(posedge clk) disable iff (!arst_n)
      (tckRise && !trstS && state_reg == PAUDR)
      |=> $stable(idShift_reg) && $stable(bsrShift_reg)) else $error("data shifted in pause");

   a_update_dr: assert property (@(posedge clk) disable iff (!arst_n)
      (tckFall && state_reg == UPDDR && selBsr) |=> bsrUpd_reg == $past(bsrShift_reg))
      else $error("boundary update wrong");

   a_extest_drive: assert property (@(posedge clk) disable iff (!arst_n)
      extest |=> pinOut == $past(bsrUpd_reg)) else $error("extest pins wrong");

   a_core_drive: assert property (@(posedge clk) disable iff (!arst_n)
      !extest |=> pinOut == $past(coreOut)) else $error("core value not on pins");

   a_highz_bypass: assert property (@(posedge clk) disable iff (!arst_n)
      (tckRise && !trstS && highz && state_reg == SHDR) |=> bypass_reg == $past(tdiS))
      else $error("high-Z does not shift bypass");

   a_tdo_follows: assert property (@(posedge clk) disable iff (!arst_n)
      tckFall |=> tdoOut.tdo == $past(tdoBit) && tdoOut.tdoOe == $past(shifting))
      else $error("TDO not updated on falling edge");
endmodule // jtp_tap

//--- bench/jtp_tester.sv
module jtp_tester import jtp_pkg::*; (
   input wire logic clk,
   input wire jtp_out_t tdoOut,
   output jtp_pins_t pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Tester side of the test port
   // ----------------------------------------
   logic tdoWire;
   // A released TDO floats to the pull-up level, so a stale bit can never pass for data.
   assign tdoWire = tdoOut.tdoOe ? tdoOut.tdo : 1'h1;
   initial pins = '{tck: 1'h0, tms: 1'h1, tdi: 1'h0, trstN: 1'h1};
   // One TCK period of 160 ns; TCK rests low between calls, so it stands still outside frames.
   task automatic step(input logic ms, input logic di, output logic td);
      @(posedge clk);
      pins.tms <= ms;
      pins.tdi <= di;
      repeat (3) @(posedge clk);
      td = tdoWire;
      pins.tck <= 1'h1;
      repeat (8) @(posedge clk);
      pins.tck <= 1'h0;
      repeat (4) @(posedge clk);
   endtask
   task automatic reset_tap();
      logic t;
      repeat (5) step(1'h1, 1'h0, t);
      step(1'h0, 1'h0, t);
   endtask
   task automatic trst();
      logic t;
      @(posedge clk);
      pins.trstN <= 1'h0;
      repeat (8) @(posedge clk);
      pins.trstN <= 1'h1;
      repeat (8) @(posedge clk);
      step(1'h0, 1'h0, t);
   endtask
   // Scan from idle back to idle; pz pauses after the second bit, which needs n above 2.
   task automatic scan(input logic ir, input logic pz, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic t;
      dout = '0;
      step(1'h1, 1'h0, t);
      if (ir) step(1'h1, 1'h0, t);
      step(1'h0, 1'h0, t);
      step(1'h0, 1'h0, t);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1 || (pz && i == 1), din[i], t);
         dout[i] = t;
         if (pz && i == 1) begin
            step(1'h0, ~din[i], t);
            step(1'h1, din[i], t);
            step(1'h0, ~din[i], t);
         end
      end
      step(1'h1, 1'h0, t);
      step(1'h0, 1'h0, t);
   endtask
endmodule // jtp_tester

//--- bench/tb.sv
module tb import jtp_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] VER = 4'h0;
   localparam logic [15:0] PART = 16'h1234; // Arbitrary value.
   localparam logic [10:0] MFR = 11'h055; // Arbitrary value.
   logic clk = 1'h0;
   logic arst_n = 1'h0;
   logic [7:0] pinIn = 8'h00;
   logic [7:0] coreOut = 8'h5A;
   logic [7:0] pinOut;
   logic pinOutOe, memEnable, t;
   logic [31:0] got;
   jtp_pins_t pins;
   jtp_out_t tdoOut;
   int fails = 0;
   int tests_run = 0;
   always #5 clk = ~clk;
   jtp_tester tester (.clk(clk), .tdoOut(tdoOut), .pins(pins));
   jtp_tap #(.BSR_W(8), .VERSION(VER), .PART_NUM(PART), .MFR_ID(MFR)) uut (.clk(clk),
      .arst_n(arst_n), .pins(pins), .pinIn(pinIn), .coreOut(coreOut), .tdoOut(tdoOut),
      .pinOut(pinOut), .pinOutOe(pinOutOe), .memEnable(memEnable));
   // ----------------------------------------
   // Checking and scenarios
   // ----------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("unexpected at %0t: got %0h exp %0h", $time, g, e);
      end
   endtask
   task automatic give_verdict();
      if (fails == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic t_reset();
      chk(memEnable, 1'h1);
      chk(tdoOut.tdoOe, 1'h0);
      chk({pinOutOe, pinOut}, {1'h1, coreOut});
      tester.step(1'h0, 1'h0, t);
      tester.scan(1'h0, 1'h0, 2, 32'h3, got);
      chk(got[1:0], 2'h2);
   endtask
   task automatic t_idcode();
      tester.scan(1'h1, 1'h1, 4, 32'h2, got);
      chk(got[1:0], 2'h1);
      tester.scan(1'h0, 1'h1, 32, 32'h0, got);
      chk(got, {VER, PART, MFR, 1'h1});
   endtask
   // Leaves the loaded identification instruction behind; five ones must discard it.
   task automatic t_five();
      tester.step(1'h1, 1'h0, t);
      tester.step(1'h0, 1'h0, t);
      tester.step(1'h0, 1'h0, t);
      tester.reset_tap();
      tester.scan(1'h0, 1'h0, 2, 32'h1, got);
      chk(got[1:0], 2'h2);
      chk(memEnable, 1'h1);
   endtask
   task automatic t_bsr();
      @(posedge clk) pinIn <= 8'hA5;
      tester.scan(1'h1, 1'h0, 4, 32'h1, got);
      tester.scan(1'h0, 1'h0, 8, 32'h3C, got);
      chk(got[7:0], 8'hA5);
      chk(pinOut, coreOut);
      tester.scan(1'h1, 1'h0, 4, 32'h0, got);
      chk({pinOutOe, pinOut}, {1'h1, 8'h3C});
   endtask
   task automatic t_highz();
      tester.scan(1'h1, 1'h0, 4, 32'h3, got);
      chk(pinOutOe, 1'h0);
      tester.scan(1'h0, 1'h1, 3, 32'h5, got);
      chk(got[2:0], 3'h2);
      chk(tdoOut.tdoOe, 1'h0);
   endtask
   task automatic t_trst();
      tester.trst();
      chk({pinOutOe, pinOut}, {1'h1, coreOut});
      tester.scan(1'h0, 1'h0, 2, 32'h3, got);
      chk(got[1:0], 2'h2);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'h1;
      repeat (2) @(posedge clk);
      t_reset();
      t_idcode();
      t_five();
      t_bsr();
      t_highz();
      t_trst();
      give_verdict();
   end
   initial begin
      #1ms;
      fails++;
      give_verdict();
   end
endmodule // tb
